/* logic/tfoc_pkg.sv */
// package for the temperature format and overtemperature output configuration block
// assumes an 8-bit register port reached by a serial management bus front end outside
package tfoc_pkg;
    localparam logic [7:0] CFG_OFFSET    = 8'h7c;
    localparam logic [7:0] CFG_RESET     = 8'h01;
    localparam int         BIT_SIGNED    = 0;
    localparam int         BIT_OFS_COARSE = 1;
    localparam int         BIT_CPU_EN    = 4;
    localparam int         BIT_RA_EN     = 5;
    localparam int         BIT_LOC_EN    = 6;
    localparam int         BIT_RB_EN     = 7;
    // limit codes that switch a channel off, then the offset-64 bias
    localparam logic [7:0] OFS64_OFF     = 8'h00;
    localparam logic [7:0] SIGNED_OFF    = 8'h80;
    localparam logic [7:0] OFS64_BIAS    = 8'h40;
    localparam int         NCH           = 4;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tfoc_wr_t;

    typedef struct packed {
        logic [7:0] cpu;
        logic [7:0] remote_a;
        logic [7:0] local_t;
        logic [7:0] remote_b;
    } tfoc_temps_t;
endpackage

/* logic/tfoc_top.sv */
// configuration register and overtemperature pin drive logic
// assumes temperatures and limits arrive in the currently selected encoding,
// and that the bus front end presents single-cycle write strobes
// Notes on behaviour
// - bit 0 set selects twos complement encoding; clear selects offset-64 encoding.
// - after an encoding change, readings and limits are compared in the new encoding.
// - bit 1 clear gives half-degree offsets; set gives whole-degree, wider offsets.
// - offset resolution applies to remote and local offsets; cpu offset always whole-degree.
// - bit 4 with cpu reading above its limit drives the overtemperature pin.
// - bit 5 with remote a reading above its limit drives the pin.
// - bit 6 with local reading above its limit drives the pin.
// - bit 7 with remote b reading above its limit drives the pin.
// - a channel with its enable clear never drives; with bits 4 to 7 all clear the pin only feeds the timer.
// - limit at minus 64 offset-64 or minus 128 signed disables that channel.
// - register resets to 0x01.
// - when the lock input is set, writes to the register are ignored.
// - assertion timer beyond its limit raises a status flag; zero flags at once.
`timescale 1ns/1ns
module tfoc_top (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    // register access
    input  wire tfoc_pkg::tfoc_wr_t   reg_wr,
    input  wire logic                 cfg_lock,
    output logic      [7:0]           cfg_rdata,
    // measurements and limits
    input  wire logic                 meas_done,
    input  wire tfoc_pkg::tfoc_temps_t temps,
    input  wire tfoc_pkg::tfoc_temps_t limits,
    // decoded mode outputs
    output logic                      signed_range_select,
    output logic                      offset_coarse,
    output logic                      cpu_offset_coarse,
    // overtemperature pin
    input  wire logic                 overtemp_pin_in,
    output logic                      overtemp_pin_out,
    output logic                      overtemp_pin_oe,
    // timer limit flag
    input  wire logic                 timer_tick,
    input  wire logic      [7:0]      timer_limit,
    output logic                      timer_flag
);
    logic [7:0] cfg_reg, cfg_next;
    logic       drive_reg, drive_next;
    logic [7:0] tmr_reg, tmr_next;
    logic       flag_reg, flag_next;
    logic [tfoc_pkg::NCH-1:0] trip;
    logic [tfoc_pkg::NCH-1:0] ch_en;
    logic [7:0] t_v [tfoc_pkg::NCH];
    logic [7:0] l_v [tfoc_pkg::NCH];

    assign t_v[0] = temps.cpu;
    assign t_v[1] = temps.remote_a;
    assign t_v[2] = temps.local_t;
    assign t_v[3] = temps.remote_b;
    assign l_v[0] = limits.cpu;
    assign l_v[1] = limits.remote_a;
    assign l_v[2] = limits.local_t;
    assign l_v[3] = limits.remote_b;

    assign ch_en = cfg_reg[tfoc_pkg::BIT_RB_EN:tfoc_pkg::BIT_CPU_EN];

    // register write path
    always_comb begin
        cfg_next = cfg_reg;
        if (reg_wr.wr_en && reg_wr.addr == tfoc_pkg::CFG_OFFSET && !cfg_lock) begin
            cfg_next = reg_wr.wdata;
        end
    end

    // per channel comparison in the selected encoding
    always_comb begin
        logic [7:0] tb;
        logic [7:0] lb;
        logic       off;
        tb  = 8'h00;
        lb  = 8'h00;
        off = 1'b0;
        trip = '0;
        for (int i = 0; i < tfoc_pkg::NCH; i++) begin
            if (signed_range_select) begin
                // bias signed codes so an unsigned compare orders them
                tb  = t_v[i] ^ tfoc_pkg::SIGNED_OFF;
                lb  = l_v[i] ^ tfoc_pkg::SIGNED_OFF;
                off = (l_v[i] == tfoc_pkg::SIGNED_OFF);
            end else begin
                tb  = t_v[i];
                lb  = l_v[i];
                off = (l_v[i] == tfoc_pkg::OFS64_OFF);
            end
            trip[i] = ch_en[i] && !off && (tb > lb);
        end
    end

    // pin drive and assertion timer
    always_comb begin
        drive_next = drive_reg;
        tmr_next   = tmr_reg;
        flag_next  = flag_reg;
        if (meas_done) begin
            drive_next = |trip;
        end
        if (ch_en == '0) begin
            drive_next = 1'b0;
        end
        if (!overtemp_pin_in) begin
            if (timer_limit == 8'h00) begin
                flag_next = 1'b1;
            end else if (timer_tick && tmr_reg != 8'hff) begin
                tmr_next = tmr_reg + 8'h01;
            end
            if (tmr_reg > timer_limit) begin
                flag_next = 1'b1;
            end
        end else begin
            tmr_next = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_reg   <= tfoc_pkg::CFG_RESET;
            drive_reg <= 1'b0;
            tmr_reg   <= 8'h00;
            flag_reg  <= 1'b0;
        end else begin
            cfg_reg   <= cfg_next;
            drive_reg <= drive_next;
            tmr_reg   <= tmr_next;
            flag_reg  <= flag_next;
        end
    end

    assign cfg_rdata           = cfg_reg;
    assign signed_range_select = cfg_reg[tfoc_pkg::BIT_SIGNED];
    assign offset_coarse       = cfg_reg[tfoc_pkg::BIT_OFS_COARSE];
    assign cpu_offset_coarse   = 1'b1;
    assign overtemp_pin_out    = 1'b0;
    assign overtemp_pin_oe     = drive_reg;
    assign timer_flag          = flag_reg;
endmodule

/* verification/tfoc_monitor.sv */
// checker for the configuration register and pin drive
// assumes binding to tfoc_top, ports matched by name
`timescale 1ns/1ns
module tfoc_monitor (
    // watched ports
    input wire logic               ref_clk,
    input wire logic               srst,
    input wire tfoc_pkg::tfoc_wr_t reg_wr,
    input wire logic               cfg_lock,
    input wire logic [7:0]         cfg_rdata,
    input wire logic               meas_done,
    input wire logic               signed_range_select,
    input wire logic               offset_coarse,
    input wire logic               cpu_offset_coarse,
    input wire logic               overtemp_pin_in,
    input wire logic               overtemp_pin_out,
    input wire logic               overtemp_pin_oe,
    input wire logic [7:0]         timer_limit,
    input wire logic               timer_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire acc = reg_wr.wr_en && reg_wr.addr == 8'h7c && !cfg_lock;
    write_take_a: assert property (acc |=> cfg_rdata == $past(reg_wr.wdata)) else $error("write lost");
    write_lock_a: assert property (!acc |=> $stable(cfg_rdata)) else $error("stray write");
    reset_val_a: assert property (disable iff (1'b0) srst |=> cfg_rdata == 8'h01 && !overtemp_pin_oe
        && !timer_flag) else $error("bad reset");
    enc_sel_a: assert property (signed_range_select == cfg_rdata[0]) else $error("bad encoding");
    ofs_sel_a: assert property (offset_coarse == cfg_rdata[1] && cpu_offset_coarse)
        else $error("bad offset mode");
    pin_low_a: assert property (!overtemp_pin_out) else $error("pin driven high");
    no_enable_a: assert property (cfg_rdata[7:4] == 4'h0 |=> !overtemp_pin_oe) else $error("pin drive");
    oe_hold_a: assert property (!meas_done && cfg_rdata[7:4] != 4'h0 |=> $stable(overtemp_pin_oe))
        else $error("drive moved");
    flag_now_a: assert property (timer_limit == 8'h00 && !overtemp_pin_in |=> timer_flag)
        else $error("no flag");
    flag_keep_a: assert property (timer_flag |=> timer_flag) else $error("flag lost");
    cover property (meas_done ##1 overtemp_pin_oe);
    cover property (reg_wr.wr_en && cfg_lock);
    cover property ($rose(timer_flag));
endmodule

/* verification/tfoc_host.sv */
// host model: register writes and timer limit
// assumes writes launch on the falling edge
`timescale 1ns/1ns
module tfoc_host (
    // clock
    input  wire logic          ref_clk,
    // toward the device
    output tfoc_pkg::tfoc_wr_t reg_wr,
    output logic [7:0]         timer_limit
);
    initial reg_wr = '0;
    initial timer_limit = 8'hff;
    // timer limit has one driver: this model
    task automatic set_limit(input logic [7:0] v);
        timer_limit = v;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk) reg_wr = '{1'b1, a, d};
        @(negedge ref_clk) reg_wr = '{1'b0, ~a, ~d};
    endtask
endmodule

/* verification/test_temp_format_overtemp_output_config.sv */
// bench for the configuration register and pin drive
// assumes tfoc_host and tfoc_monitor
`timescale 1ns/1ns
module test_temp_format_overtemp_output_config;
    typedef struct {logic [7:0] c, t, l; logic e;} tfoc_row_t;
    logic ref_clk = 0, srst = 1, cfg_lock = 0, meas_done = 0, ext_low = 0;
    tfoc_pkg::tfoc_temps_t temps = '0, limits = '0;
    tfoc_pkg::tfoc_wr_t reg_wr;
    logic [7:0] timer_limit, cfg_rdata;
    logic pin_oe, flag;
    logic tick = 0;
    wire pin_in = !(pin_oe | ext_low);
    int bad_count = 0, comparisons = 0;
    tfoc_row_t rows[10] = '{'{8'h11, 8'h50, 8'h40, 1}, '{8'h21, 8'h50, 8'h40, 1}, '{8'h41, 8'h50, 8'h40, 1},
        '{8'h81, 8'h50, 8'h40, 1}, '{8'h01, 8'h50, 8'h40, 0}, '{8'hf1, 8'h10, 8'hf0, 1},
        '{8'hf0, 8'h10, 8'hf0, 0}, '{8'hf1, 8'h10, 8'h80, 0}, '{8'hf0, 8'h10, 8'h00, 0},
        '{8'hf0, 8'h40, 8'h40, 0}};
    tfoc_host i_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .timer_limit(timer_limit));
    tfoc_top i_dut (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .cfg_lock(cfg_lock), .cfg_rdata(cfg_rdata),
        .meas_done(meas_done), .temps(temps), .limits(limits), .signed_range_select(), .offset_coarse(),
        .cpu_offset_coarse(), .overtemp_pin_in(pin_in), .overtemp_pin_out(), .overtemp_pin_oe(pin_oe),
        .timer_tick(tick), .timer_limit(timer_limit), .timer_flag(flag));
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        srst = 0;
        chk("reset cfg", cfg_rdata, 8'h01);
        foreach (rows[i]) begin
            i_host.wr(8'h7c, rows[i].c);
            temps = {4{rows[i].t}};
            limits = {4{rows[i].l}};
            meas_done = 1;
            @(negedge ref_clk) meas_done = 0;
            chk("pin drive", pin_oe, rows[i].e);
            $display("row %0d done", i);
        end
        i_host.wr(8'h7c, 8'h0c);
        chk("reserved", cfg_rdata, 8'h0c);
        i_host.wr(8'h7d, 8'hf3);
        chk("other addr", cfg_rdata, 8'h0c);
        cfg_lock = 1;
        i_host.wr(8'h7c, 8'h55);
        chk("locked", cfg_rdata, 8'h0c);
        cfg_lock = 0;
        i_host.set_limit(8'h00);
        ext_low = 1;
        @(negedge ref_clk) chk("flag", flag, 8'h01);
        srst = 1;
        @(negedge ref_clk) srst = 0;
        chk("reset cfg", cfg_rdata, 8'h01);
        chk("reset flag", flag, 8'h00);
        // counted assertion time against a nonzero limit, pin held low
        i_host.set_limit(8'h02);
        srst = 1;
        @(negedge ref_clk) srst = 0;
        repeat (2) begin
            tick = 1;
            @(negedge ref_clk) tick = 0;
            @(negedge ref_clk);
        end
        chk("flag at limit", flag, 8'h00);
        tick = 1;
        @(negedge ref_clk) tick = 0;
        @(negedge ref_clk);
        chk("flag past limit", flag, 8'h01);
        $display("register, timer and reset tests done");
        give_verdict();
    end
endmodule
bind tfoc_top tfoc_monitor i_mon (.*);
